// ===== verilog/dam_alarm_manager.sv
// alarm latch, clear handling and display state for the drive
`include "dam_cfg.svh"
module dam_alarm_manager #(
   parameter int unsigned MS_CYC = `DAM_MS_NS / `DAM_CLK_NS
) (
   // clock, reset, enable
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic ce,
   // asynchronous pins
   input wire dam_pkg::dam_pin_type pins,
   // configuration
   input wire dam_pkg::dam_cfg_type cfg,
   // history read
   input wire logic [3:0] histIdx,
   output logic [7:0] histCode,
   // status
   output dam_pkg::dam_out_type st
);
   dam_pkg::dam_state_type s_r;
   dam_pkg::dam_state_type s_nxt;
   logic tick;
   logic runCmd;
   logic clrFall;
   logic swFall;
   logic runFall;
   logic extFell;
   logic olExp;
   logic inClr;
   logic panelAcc;
   logic lockClr;
   logic doClr;
   logic push;
   logic [7:0] newCode;

   // codes that only a power cycle removes
   function automatic logic clearable(input logic [7:0] c);
      clearable = (c != `DAM_CODE_NVM) && (c != `DAM_CODE_SENSPU);
   endfunction : clearable

   // falling edge between two synchronised samples
   function automatic logic fell(input logic prev, input logic cur);
      fell = prev && !cur;
   endfunction : fell

   // alarms during operation, in priority order
   function automatic logic [7:0] runPick(input dam_pkg::dam_pin_type p,
         input logic ol, input logic ext);
      if (p.nvmFault) runPick = `DAM_CODE_NVM;
      else if (p.supplyLow) runPick = `DAM_CODE_UV;
      else if (p.sensorLost) runPick = `DAM_CODE_SENS;
      else if (p.overspeed) runPick = `DAM_CODE_OVS;
      else if (ol) runPick = `DAM_CODE_OVL;
      else if (ext) runPick = `DAM_CODE_EXT;
      else runPick = `DAM_CODE_NONE;
   endfunction : runPick

   // one-shot checks at power-up
   function automatic logic [7:0] upPick(input dam_pkg::dam_pin_type p,
         input dam_pkg::dam_cfg_type c);
      logic lock;
      lock = c.extOpEnable ? (p.forwardRunInput || p.reverseRunInput) :
         p.runSwitch;
      if (p.nvmFault) upPick = `DAM_CODE_NVM;
      else if (p.sensorLost) upPick = `DAM_CODE_SENSPU;
      else if (lock && c.lockoutEnable) upPick = `DAM_CODE_LOCK;
      else if (p.supplyLow) upPick = `DAM_CODE_UV;
      else upPick = `DAM_CODE_NONE;
   endfunction : upPick

   // edges and conditions from synchronised pins
   always_comb begin
      tick = s_r.tickCnt == 16'(MS_CYC - 1);
      runCmd = s_r.sy2.forwardRunInput || s_r.sy2.reverseRunInput;
      clrFall = fell(s_r.sy3.faultClearInput, s_r.sy2.faultClearInput);
      swFall = fell(s_r.sy3.runSwitch, s_r.sy2.runSwitch);
      runFall = fell(s_r.sy3.forwardRunInput || s_r.sy3.reverseRunInput,
         runCmd);
      extFell = cfg.extStopAssigned && fell(s_r.sy3.externalFaultInput,
         s_r.sy2.externalFaultInput);
      olExp = s_r.sy2.loadOverLimit || (s_r.sy2.loadOverCont &&
         s_r.olMs > cfg.overloadMs);
   end

   // which clear requests are honoured
   always_comb begin
      inClr = cfg.clearInputAssigned && clrFall && !runCmd &&
         clearable(s_r.code);
      panelAcc = s_r.armed && s_r.sy2.panelClear &&
         !s_r.sy3.panelClear && clearable(s_r.code);
      lockClr = (s_r.code == `DAM_CODE_LOCK) && (swFall ||
         (cfg.lockoutAltClear && runFall));
      doClr = s_r.alarm && (inClr || panelAcc || lockClr);
      case (s_r.phase)
         dam_pkg::PH_CHECK: newCode = upPick(s_r.sy2, cfg);
         dam_pkg::PH_RUN: newCode = runPick(s_r.sy2, olExp, extFell);
         default: newCode = `DAM_CODE_NONE;
      endcase
      push = (!s_r.alarm || doClr) && (newCode != `DAM_CODE_NONE);
   end

   // next state
   always_comb begin
      s_nxt = s_r;
      // pin synchronisers and edge history
      s_nxt.sy1 = pins;
      s_nxt.sy2 = s_r.sy1;
      s_nxt.sy3 = s_r.sy2;
      // millisecond tick
      s_nxt.tickCnt = tick ? 16'h0000 : s_r.tickCnt + 16'h0001;
      // power-up sequence
      case (s_r.phase)
         dam_pkg::PH_START: begin
            s_nxt.startCnt = s_r.startCnt + 2'h1;
            if (s_r.startCnt == `DAM_START_CYC) begin
               s_nxt.phase = dam_pkg::PH_CHECK;
            end
         end
         dam_pkg::PH_CHECK: s_nxt.phase = dam_pkg::PH_RUN;
         dam_pkg::PH_RUN: s_nxt.phase = dam_pkg::PH_RUN;
         default: s_nxt.phase = dam_pkg::PH_START;
      endcase
      // overload time accumulates in milliseconds, saturating
      if (!s_r.sy2.loadOverCont) begin
         s_nxt.olMs = 16'h0000;
      end else if (tick && s_r.olMs != 16'hFFFF) begin
         s_nxt.olMs = s_r.olMs + 16'h0001;
      end
      // panel clear arms on switch run to standby
      if (s_r.alarm && swFall) begin
         s_nxt.armed = 1'b1;
      end
      // clear first, then a new alarm wins the same cycle
      if (doClr) begin
         s_nxt.alarm = 1'b0;
         s_nxt.code = `DAM_CODE_NONE;
         s_nxt.armed = 1'b0;
         s_nxt.olMs = 16'h0000;
         s_nxt.show = 1'b1;
         s_nxt.showMs = 12'h000;
      end
      if (push) begin
         s_nxt.alarm = 1'b1;
         s_nxt.code = newCode;
         s_nxt.armed = 1'b0;
         s_nxt.show = 1'b0;
      end
      // reset indication lasts two seconds
      if (s_r.show && tick && !doClr) begin
         s_nxt.showMs = s_r.showMs + 12'h001;
         if (s_r.showMs == `DAM_SHOW_MS - 12'h001) begin
            s_nxt.show = 1'b0;
         end
      end
      // history erase walks all slots
      if (s_r.erase) begin
         s_nxt.eraseIdx = s_r.eraseIdx + 4'h1;
         if (s_r.eraseIdx == `DAM_HIST_LAST) begin
            s_nxt.erase = 1'b0;
         end
      end else if (s_r.sy2.panelHistClear && !s_r.sy3.panelHistClear) begin
         s_nxt.erase = 1'b1;
         s_nxt.eraseIdx = 4'h0;
      end
   end

   // state register
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         s_r <= '0;
      end else if (ce) begin
         s_r <= s_nxt;
      end
   end

   // outputs to drive and display
   always_comb begin
      st.alarmActive = s_r.alarm;
      st.alarmCode = s_r.code;
      st.driveEnable = (s_r.phase == dam_pkg::PH_RUN) && !s_r.alarm;
      st.quickStop = s_r.alarm && (s_r.code == `DAM_CODE_EXT) &&
         !s_r.sy2.motorStopped;
      st.holdEnable = !s_r.alarm || st.quickStop;
      st.resetShow = s_r.show;
      st.histBlink = s_r.erase;
   end

   // alarm history store
   dam_history u_hist (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .ce(ce),
      .push(push),
      .pushCode(newCode),
      .wipe(s_r.erase),
      .wipeIdx(s_r.eraseIdx),
      .rdIdx(histIdx),
      .rdCode(histCode)
   );

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!reset_n);

   property p_uv;
      ce && s_r.phase == dam_pkg::PH_RUN && !s_r.alarm &&
         s_r.sy2.supplyLow && !s_r.sy2.nvmFault
         |=> s_r.alarm && s_r.code == `DAM_CODE_UV;
   endproperty
   a_uv: assert property (p_uv)
      else $error("undervoltage not latched");

   property p_ovs;
      ce && s_r.phase == dam_pkg::PH_RUN && !s_r.alarm &&
         s_r.sy2.overspeed && !s_r.sy2.nvmFault && !s_r.sy2.supplyLow &&
         !s_r.sy2.sensorLost |=> s_r.code == `DAM_CODE_OVS;
   endproperty
   a_ovs: assert property (p_ovs)
      else $error("overspeed not latched");

   property p_drive;
      s_r.alarm |-> !st.driveEnable && st.alarmCode != `DAM_CODE_NONE;
   endproperty
   a_drive: assert property (p_drive)
      else $error("drive enabled during alarm");

   property p_nvm;
      ce && s_r.alarm && s_r.code == `DAM_CODE_NVM
         |=> s_r.alarm && s_r.code == `DAM_CODE_NVM;
   endproperty
   a_nvm: assert property (p_nvm)
      else $error("stored-data alarm was cleared");

   property p_clr;
      ce && s_r.alarm && cfg.clearInputAssigned && clrFall && !runCmd &&
         clearable(s_r.code) && newCode == `DAM_CODE_NONE |=> !s_r.alarm;
   endproperty
   a_clr: assert property (p_clr)
      else $error("falling clear edge did not clear");

   property p_runblk;
      ce && s_r.alarm && runCmd && !panelAcc && !lockClr |=> s_r.alarm;
   endproperty
   a_runblk: assert property (p_runblk)
      else $error("clear taken during run command");

   property p_show;
      ce && doClr && !push |=> st.resetShow && !st.alarmActive;
   endproperty
   a_show: assert property (p_show)
      else $error("reset indication missing");

   property p_lock;
      ce && s_r.phase == dam_pkg::PH_CHECK && !cfg.lockoutEnable
         |=> s_r.code != `DAM_CODE_LOCK;
   endproperty
   a_lock: assert property (p_lock)
      else $error("lockout raised while disabled");
endmodule : dam_alarm_manager

// ===== verilog/dam_cfg.svh
// constants for the drive alarm manager
`ifndef DAM_CFG_SVH
`define DAM_CFG_SVH
// clock period and one millisecond, in ns
`define DAM_CLK_NS 32'h0000_0019
`define DAM_MS_NS 32'h000F_4240
// reset indication time, 2000 ms
`define DAM_SHOW_MS 12'h07D0
// cycles after reset before the power-up check
`define DAM_START_CYC 2'h3
// history depth and last index
`define DAM_HIST_DEPTH 9
`define DAM_HIST_LAST 4'h8
// alarm codes
`define DAM_CODE_NONE 8'h00
`define DAM_CODE_UV 8'h25
`define DAM_CODE_SENS 8'h28
`define DAM_CODE_OVL 8'h30
`define DAM_CODE_OVS 8'h31
`define DAM_CODE_NVM 8'h41
`define DAM_CODE_SENSPU 8'h42
`define DAM_CODE_LOCK 8'h46
`define DAM_CODE_EXT 8'h6E
`endif

// ===== verilog/dam_pkg.sv
// types for the drive alarm manager
package dam_pkg;
   // pins from sensors, switch and control terminals
   typedef struct packed {
      logic supplyLow;
      logic sensorLost;
      logic loadOverCont;
      logic loadOverLimit;
      logic overspeed;
      logic nvmFault;
      logic runSwitch;
      logic forwardRunInput;
      logic reverseRunInput;
      logic externalFaultInput;
      logic faultClearInput;
      logic panelClear;
      logic panelHistClear;
      logic motorStopped;
   } dam_pin_type;
   // configuration parameters
   typedef struct packed {
      logic extOpEnable;
      logic lockoutEnable;
      logic extStopAssigned;
      logic clearInputAssigned;
      logic lockoutAltClear;
      logic [15:0] overloadMs;
   } dam_cfg_type;
   // status toward the drive and display
   typedef struct packed {
      logic driveEnable;
      logic holdEnable;
      logic quickStop;
      logic alarmActive;
      logic [7:0] alarmCode;
      logic resetShow;
      logic histBlink;
   } dam_out_type;
   typedef enum logic [1:0] {PH_START, PH_CHECK, PH_RUN} dam_phase_type;
   typedef struct packed {
      dam_phase_type phase;
      logic [1:0] startCnt;
      dam_pin_type sy1;
      dam_pin_type sy2;
      dam_pin_type sy3;
      logic alarm;
      logic [7:0] code;
      logic armed;
      logic [15:0] olMs;
      logic [15:0] tickCnt;
      logic show;
      logic [11:0] showMs;
      logic erase;
      logic [3:0] eraseIdx;
   } dam_state_type;
   typedef struct packed {
      logic [8:0][7:0] slot;
      logic [7:0] rd;
   } dam_hist_type;
endpackage : dam_pkg

// ===== verilog/dam_history.sv
// nine-entry alarm history, newest first
`include "dam_cfg.svh"
module dam_history (
   // clock and reset
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic ce,
   // new entry
   input wire logic push,
   input wire logic [7:0] pushCode,
   // erase one slot
   input wire logic wipe,
   input wire logic [3:0] wipeIdx,
   // read port
   input wire logic [3:0] rdIdx,
   output logic [7:0] rdCode
);
   dam_pkg::dam_hist_type h_r;
   dam_pkg::dam_hist_type h_nxt;

   // shift in newest, oldest falls off the end
   always_comb begin
      h_nxt = h_r;
      if (push) begin
         for (int i = `DAM_HIST_DEPTH - 1; i > 0; i--) begin
            h_nxt.slot[i] = h_r.slot[i - 1];
         end
         h_nxt.slot[0] = pushCode;
      end
      if (wipe && wipeIdx <= `DAM_HIST_LAST) begin
         h_nxt.slot[wipeIdx] = `DAM_CODE_NONE;
      end
      h_nxt.rd = (rdIdx <= `DAM_HIST_LAST) ? h_r.slot[rdIdx] :
         `DAM_CODE_NONE;
   end

   // state register
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         h_r <= '0;
      end else if (ce) begin
         h_r <= h_nxt;
      end
   end

   assign rdCode = h_r.rd;

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!reset_n);

   property p_push;
      ce && push && !wipe |=> h_r.slot[0] == $past(pushCode);
   endproperty
   a_push: assert property (p_push)
      else $error("newest entry not stored");

   property p_age;
      ce && push && !wipe |=> h_r.slot[8] == $past(h_r.slot[7]);
   endproperty
   a_age: assert property (p_age)
      else $error("history did not age by one slot");
endmodule : dam_history

// ===== dv/dam_far_side.sv
// far-side model: motor sensors, operator switch and control terminals
module dam_far_side #(
   parameter int unsigned HOLD_CYC = 40
) (
   // clock
   input wire logic ref_clk,
   // pin levels toward the alarm manager
   output dam_pkg::dam_pin_type pins
);
   timeunit 1ns;
   timeprecision 1ps;
   // all lines quiet, fault input healthy
   dam_pkg::dam_pin_type p = 14'h0010;
   // levels reach the pins unchanged
   assign pins = p;
   // move one pin just after a falling edge
   task pin(input int b, input logic v);
      @(negedge ref_clk);
      p[b] = v;
   endtask : pin
   // clear input held high for the minimum time, then dropped
   task clearPulse();
      @(negedge ref_clk);
      p.faultClearInput = 1'b1;
      repeat (HOLD_CYC) @(negedge ref_clk);
      p.faultClearInput = 1'b0;
   endtask : clearPulse
endmodule : dam_far_side

// ===== dv/dam_alarm_manager_tb.sv
// self-checking bench for the drive alarm manager
`include "dam_cfg.svh"
module dam_alarm_manager_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int unsigned MS = 4;
   logic ref_clk = 1'b0;
   logic reset_n = 1'b0;
   logic ce = 1'b1;
   dam_pkg::dam_cfg_type cfg = 21'h0_0000;
   logic [3:0] histIdx = 4'h0;
   logic [7:0] histCode;
   dam_pkg::dam_pin_type pins;
   dam_pkg::dam_out_type st;
   int err_count = 0;
   int checks_done = 0;
   int n;
   // pin index, fault level and expected code of each clearable run-time alarm
   int bits [5] = '{13, 9, 12, 10, 4};
   logic lv [5] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
   logic [7:0] codes [5] = '{`DAM_CODE_UV, `DAM_CODE_OVS, `DAM_CODE_SENS,
      `DAM_CODE_OVL, `DAM_CODE_EXT};

   // 40 MHz clock
   always #12.5 ref_clk = ~ref_clk;

   // far side and device
   dam_far_side #(.HOLD_CYC(10 * MS)) i_far (.ref_clk(ref_clk), .pins(pins));
   dam_alarm_manager #(.MS_CYC(MS)) i_dut (.ref_clk(ref_clk),
      .reset_n(reset_n), .ce(ce), .pins(pins), .cfg(cfg),
      .histIdx(histIdx), .histCode(histCode), .st(st));

   // compare and count
   task chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         err_count++;
         $display("BAD %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   // counts and verdict
   task stop_test();
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : stop_test
   // bounded wait for the alarm flag
   task waitAlarm(input logic v);
      n = 0;
      while (st.alarmActive !== v && n < 40) begin
         @(negedge ref_clk);
         n++;
      end
      if (st.alarmActive !== v) begin
         chk("alarmActive", {7'h00, st.alarmActive}, {7'h00, v});
         stop_test();
      end
   endtask : waitAlarm
   // reset with the given lockout enable
   task doReset(input logic lockEn);
      @(negedge ref_clk);
      reset_n = 1'b0;
      cfg.lockoutEnable = lockEn;
      repeat (5) @(negedge ref_clk);
      reset_n = 1'b1;
   endtask : doReset
   // registered history read, one cycle late
   task readHist(input logic [3:0] idx);
      @(negedge ref_clk);
      histIdx = idx;
      repeat (2) @(negedge ref_clk);
   endtask : readHist

   // main sequence
   initial begin
      cfg.extStopAssigned = 1'b1;
      cfg.clearInputAssigned = 1'b1;
      cfg.overloadMs = 16'h0003;
      // switch on at power-up but lockout disabled
      i_far.pin(7, 1'b1);
      doReset(1'b0);
      repeat (12) @(negedge ref_clk);
      chk("alarmActive", {7'h00, st.alarmActive}, 8'h00);
      chk("driveEnable", {7'h00, st.driveEnable}, 8'h01);
      $display("test lockout_off done");
      // lockout latched, cleared by switch to standby
      doReset(1'b1);
      waitAlarm(1'b1);
      chk("code", st.alarmCode, `DAM_CODE_LOCK);
      chk("driveEnable", {7'h00, st.driveEnable}, 8'h00);
      i_far.pin(7, 1'b0);
      waitAlarm(1'b0);
      chk("resetShow", {7'h00, st.resetShow}, 8'h01);
      $display("test lockout done");
      // each clearable run-time alarm raised, shown and cleared by the input
      for (int i = 0; i < 5; i++) begin
         i_far.pin(bits[i], lv[i]);
         waitAlarm(1'b1);
         chk("code", st.alarmCode, codes[i]);
         chk("quickStop", {7'h00, st.quickStop}, {7'h00, i == 4});
         chk("holdEnable", {7'h00, st.holdEnable}, {7'h00, i == 4});
         // once the motor stands, holding is released
         if (i == 4) begin
            i_far.pin(0, 1'b1);
            repeat (3) @(negedge ref_clk);
            chk("quickStop", {7'h00, st.quickStop}, 8'h00);
            chk("holdEnable", {7'h00, st.holdEnable}, 8'h00);
            i_far.pin(0, 1'b0);
         end
         i_far.pin(bits[i], !lv[i]);
         i_far.clearPulse();
         chk("alarmActive", {7'h00, st.alarmActive}, 8'h01);
         waitAlarm(1'b0);
         chk("resetShow", {7'h00, st.resetShow}, 8'h01);
      end
      $display("test run_alarms done");
      // history newest first, lockout below the five
      for (int k = 0; k < 6; k++) begin
         readHist(k[3:0]);
         chk("histCode", histCode,
            k < 5 ? codes[4 - k] : `DAM_CODE_LOCK);
      end
      $display("test history done");
      // overload only after the configured time
      i_far.pin(11, 1'b1);
      repeat (8) @(negedge ref_clk);
      chk("alarmActive", {7'h00, st.alarmActive}, 8'h00);
      waitAlarm(1'b1);
      chk("code", st.alarmCode, `DAM_CODE_OVL);
      i_far.pin(11, 1'b0);
      i_far.clearPulse();
      waitAlarm(1'b0);
      $display("test overload done");
      // clear input ignored while a run command is on
      i_far.pin(6, 1'b1);
      i_far.pin(9, 1'b1);
      waitAlarm(1'b1);
      i_far.pin(9, 1'b0);
      i_far.clearPulse();
      repeat (6) @(negedge ref_clk);
      chk("alarmActive", {7'h00, st.alarmActive}, 8'h01);
      i_far.pin(6, 1'b0);
      // clear input has no effect while it is not assigned
      cfg.clearInputAssigned = 1'b0;
      i_far.clearPulse();
      repeat (6) @(negedge ref_clk);
      chk("alarmActive", {7'h00, st.alarmActive}, 8'h01);
      cfg.clearInputAssigned = 1'b1;
      i_far.clearPulse();
      waitAlarm(1'b0);
      $display("test run_block done");
      // panel clear refused until switch goes run to standby
      // clock enable low first: nothing may latch meanwhile
      @(negedge ref_clk);
      ce = 1'b0;
      i_far.pin(13, 1'b1);
      repeat (6) @(negedge ref_clk);
      chk("alarmActive", {7'h00, st.alarmActive}, 8'h00);
      ce = 1'b1;
      waitAlarm(1'b1);
      chk("code", st.alarmCode, `DAM_CODE_UV);
      i_far.pin(13, 1'b0);
      i_far.pin(2, 1'b1);
      i_far.pin(2, 1'b0);
      repeat (6) @(negedge ref_clk);
      chk("alarmActive", {7'h00, st.alarmActive}, 8'h01);
      i_far.pin(7, 1'b1);
      repeat (4) @(negedge ref_clk);
      i_far.pin(7, 1'b0);
      repeat (4) @(negedge ref_clk);
      i_far.pin(2, 1'b1);
      waitAlarm(1'b0);
      i_far.pin(2, 1'b0);
      // indication stands 2000 ms of MS cycles, then goes
      repeat (7990) @(negedge ref_clk);
      chk("resetShow", {7'h00, st.resetShow}, 8'h01);
      repeat (12) @(negedge ref_clk);
      chk("resetShow", {7'h00, st.resetShow}, 8'h00);
      $display("test panel done");
      // history erase blinks nine cycles and empties slots
      i_far.pin(1, 1'b1);
      n = 0;
      repeat (20) begin
         @(negedge ref_clk);
         if (st.histBlink === 1'b1) n++;
      end
      chk("blinkCycles", n[7:0], 8'h09);
      i_far.pin(1, 1'b0);
      readHist(4'h0);
      chk("histCode", histCode, 8'h00);
      readHist(4'h5);
      chk("histCode", histCode, 8'h00);
      $display("test erase done");
      // stored-data error stays through a clear
      i_far.pin(8, 1'b1);
      waitAlarm(1'b1);
      chk("code", st.alarmCode, `DAM_CODE_NVM);
      i_far.pin(8, 1'b0);
      i_far.clearPulse();
      repeat (6) @(negedge ref_clk);
      chk("alarmActive", {7'h00, st.alarmActive}, 8'h01);
      $display("test stored_data done");
      // lockout from a run input with external operation enabled
      cfg.extOpEnable = 1'b1;
      cfg.lockoutAltClear = 1'b1;
      i_far.pin(6, 1'b1);
      doReset(1'b1);
      waitAlarm(1'b1);
      chk("code", st.alarmCode, `DAM_CODE_LOCK);
      i_far.pin(6, 1'b0);
      waitAlarm(1'b0);
      $display("test lockout_ext done");
      // sensor loss at power-up survives the clear input
      i_far.pin(12, 1'b1);
      doReset(1'b0);
      waitAlarm(1'b1);
      chk("code", st.alarmCode, `DAM_CODE_SENSPU);
      i_far.pin(12, 1'b0);
      i_far.clearPulse();
      repeat (6) @(negedge ref_clk);
      chk("alarmActive", {7'h00, st.alarmActive}, 8'h01);
      $display("test sensor_start done");
      stop_test();
   end
endmodule : dam_alarm_manager_tb
